//--- bench/serial_host.sv
// Host controller model driving the serial port of the stepper front end
`timescale 1ns/1ps
module serial_host (
	input wire logic clk_in,
	input wire logic sdo_in,
	output logic sck_out,
	output logic sdi_out,
	output logic serial_strobe_n_out
);
	// Idle lines: clock parked high, strobe high
	initial begin
		sck_out = 1'b1;
		sdi_out = 1'b0;
		serial_strobe_n_out = 1'b1;
	end
	// One frame of n clock pulses at 200 ns, collecting the read-out word
	task automatic send(input logic [15:0] w, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge clk_in);
		serial_strobe_n_out <= 1'b0;
		repeat (12) @(posedge clk_in);
		rx[15] = sdo_in;
		for (int i = 0; i < n; i++) begin
			sck_out <= 1'b0;
			sdi_out <= w[15 - i];
			repeat (4) @(posedge clk_in);
			sck_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			if (i < 15) begin
				rx[14 - i] = sdo_in;
			end
		end
		serial_strobe_n_out <= 1'b1;
		sdi_out <= ~sdi_out;
		repeat (12) @(posedge clk_in);
	endtask
endmodule

//--- bench/stepper_control_interface_test.sv
// Self-checking bench for the stepper control front end
`timescale 1ns/1ps
module stepper_control_interface_test;
	logic clk, rstn, psel, penable, pwrite, step, dir, clear_n, en, osc, ms_lo, ms_hi;
	logic pready, pslverr, serial_out, oe, diagnostic_pin, bridge, slp, ext, err, sck, serial_in, serial_strobe_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [5:0] angle, expa;
	logic [15:0] rx;
	wire sdo_w;
	int errors, tests_run;
	assign sdo_w = oe ? serial_out : 1'bz;
	stepper_ctrl dut_u (.mclk_in(clk), .rstn_in(rstn), .paddr_in(paddr), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .step_in(step), .direction_in(dir),
		.fault_clear_sleep_n_in(clear_n), .enable_in(en), .serial_clk_in(sck),
		.serial_in_in(serial_in), .serial_strobe_n_in(serial_strobe_n), .oscillator_pin_in(osc),
		.microstep_select_lo_in(ms_lo), .microstep_select_hi_in(ms_hi),
		.serial_out_out(serial_out), .serial_out_oe_out(oe), .diagnostic_pin_out(diagnostic_pin),
		.bridge_enable_out(bridge), .sleep_out(slp), .ext_clock_sel_out(ext),
		.phase_angle_out(angle));
	serial_host host_u (.clk_in(clk), .sdo_in(sdo_w), .sck_out(sck), .sdi_out(serial_in),
		.serial_strobe_n_out(serial_strobe_n));
	// 40 MHz core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic complete_run;
		if (errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	// One APB transfer; read data and error land in q and err
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse;
		cyc(10);
		step <= 1'b1;
		cyc(40);
		step <= 1'b0;
		cyc(40);
	endtask
	task automatic toggle(input int k);
		repeat (k) begin
			cyc(5);
			osc <= ~osc;
		end
	endtask
	task automatic t_reset;
		apb(1'b0, 8'h0C, 32'h0);
		cmp(q, 32'h0000_0008);
		cmp(diagnostic_pin, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		cmp(q, 32'h0);
		cmp(err, 1'b1);
	endtask
	task automatic t_step;
		logic [5:0] inc [4];
		inc = '{6'h10, 6'h08, 6'h04, 6'h01};
		en <= 1'b1;
		dir <= 1'b1;
		expa = 6'h08;
		for (int m = 0; m < 4; m++) begin
			{ms_hi, ms_lo} <= m[1:0];
			pulse();
			expa = expa + inc[m];
			cmp(angle, expa);
		end
		dir <= 1'b0;
		cyc(20);
		cmp(angle, expa);
		pulse();
		expa = expa - 6'h01;
		cmp(angle, expa);
		cmp(bridge, 1'b1);
		en <= 1'b0;
		pulse();
		expa = expa - 6'h01;
		cmp(angle, expa);
		cmp(bridge, 1'b0);
		en <= 1'b1;
		{ms_hi, ms_lo} <= 2'h0;
	endtask
	task automatic t_serial;
		host_u.send(16'h8003, 16, rx);
		host_u.send(16'h0004, 16, rx);
		apb(1'b0, 8'h08, 32'h0);
		cmp(q, 32'h0000_0003);
		pulse();
		expa = expa + 6'h03;
		cmp(angle, expa);
		host_u.send(16'h0000, 15, rx);
		apb(1'b0, 8'h00, 32'h0);
		cmp(q, 32'h0000_0004);
		cmp(diagnostic_pin, 1'b1);
		host_u.send(16'hC000, 16, rx);
		cmp(rx, 16'h8200 | expa);
		clear_n <= 1'b0;
		cyc(20);
		clear_n <= 1'b1;
		cyc(10);
		cmp(slp, 1'b0);
		apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		apb(1'b0, 8'h0C, 32'h0);
		cmp(q, 32'h0002_0000 | expa);
		apb(1'b1, 8'h00, 32'h0);
	endtask
	task automatic t_osc;
		apb(1'b1, 8'h04, 32'h0000_2001);
		toggle(40);
		cmp(ext, 1'b1);
		cmp(bridge, 1'b1);
		cmp(diagnostic_pin, 1'b0);
		apb(1'b0, 8'h0C, 32'h0);
		cmp(q, 32'h0002_0000 | expa);
		cyc(60);
		cmp(bridge, 1'b0);
		cmp(diagnostic_pin, 1'b1);
		apb(1'b0, 8'h0C, 32'h0);
		cmp(q, 32'h0004_8100 | expa);
		toggle(20);
		cmp(bridge, 1'b1);
		apb(1'b1, 8'h04, 32'h0);
		cyc(60);
		cmp(ext, 1'b0);
		cmp(bridge, 1'b1);
	endtask
	task automatic t_sleep;
		host_u.send(16'h4003, 16, rx);
		cmp(rx, 16'h8100 | expa);
		cmp(diagnostic_pin, 1'b0);
		clear_n <= 1'b0;
		cyc(380);
		cmp(slp, 1'b0);
		cyc(40);
		cmp(slp, 1'b1);
		cmp(bridge, 1'b0);
		cmp(diagnostic_pin, 1'b1);
		clear_n <= 1'b1;
		cyc(10);
		cmp(slp, 1'b0);
		cmp(diagnostic_pin, 1'b0);
		apb(1'b0, 8'h0C, 32'h0);
		cmp(q & 32'h0000_FFFF, expa);
	endtask
	// Second reset in mid-run brings back home angle and default selections
	task automatic t_again;
		rstn <= 1'b0;
		cyc(5);
		rstn <= 1'b1;
		cyc(4);
		cmp(angle, stepper_pkg::ANGLE_HOME);
		cmp(ext, 1'b0);
		cmp(diagnostic_pin, 1'b0);
	endtask
	// Main sequence
	initial begin
		{rstn, psel, penable, pwrite, step, dir, en, osc, ms_lo, ms_hi} = 10'h000;
		clear_n = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		cyc(5);
		rstn <= 1'b1;
		cyc(4);
		t_reset();
		t_step();
		t_serial();
		t_osc();
		t_sleep();
		t_again();
		complete_run();
	end
	// Watchdog against a hang
	initial begin
		#1000000;
		errors++;
		complete_run();
	end
endmodule

//--- bench/stepper_ctrl_assertions.sv
// Port-level checker for the stepper control front end
`timescale 1ns/1ps
module stepper_ctrl_check (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic step_in,
	input wire logic fault_clear_sleep_n_in,
	input wire logic enable_in,
	input wire logic serial_clk_in,
	input wire logic serial_strobe_n_in,
	input wire logic oscillator_pin_in,
	input wire logic serial_out_out,
	input wire logic serial_out_oe_out,
	input wire logic bridge_enable_out,
	input wire logic sleep_out,
	input wire logic ext_clock_sel_out,
	input wire logic [5:0] phase_angle_out
);
	logic [15:0] low_cnt;
	logic [15:0] osc_cnt;
	logic osc_last;
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	// Cycles the reset pin has stayed low
	always_ff @(posedge mclk_in) begin
		if (!rstn_in || fault_clear_sleep_n_in) begin
			low_cnt <= 16'h0000;
		end else if (low_cnt != 16'hFFFF) begin
			low_cnt <= low_cnt + 16'h0001;
		end
	end
	// Cycles the oscillator pin has stood still in external mode
	always_ff @(posedge mclk_in) begin
		osc_last <= oscillator_pin_in;
		if (!rstn_in || !ext_clock_sel_out || oscillator_pin_in != osc_last) begin
			osc_cnt <= 16'h0000;
		end else if (osc_cnt != 16'hFFFF) begin
			osc_cnt <= osc_cnt + 16'h0001;
		end
	end
	AST_ANGLE_HOLD: assert property (!step_in [*8] |-> $stable(phase_angle_out))
		else $error("Angle moved without a step edge");
	AST_OE_IDLE: assert property (serial_strobe_n_in [*8] |-> !serial_out_oe_out)
		else $error("Serial output driven with strobe high");
	AST_OE_RISE: assert property ($fell(serial_strobe_n_in) |-> ##[3:7] serial_out_oe_out)
		else $error("Serial output not driven after strobe fall");
	AST_BRIDGE_OFF: assert property (!enable_in [*6] |-> !bridge_enable_out)
		else $error("Bridge on while enable low");
	AST_SLEEP_ENTRY: assert property (low_cnt > 16'h019A |-> sleep_out)
		else $error("No sleep after long reset low");
	AST_SLEEP_MIN: assert property ($rose(sleep_out) |-> low_cnt >= 16'h0190)
		else $error("Sleep entered too early");
	AST_CLOCK_LOSS: assert property (osc_cnt > 16'h0032 |-> !bridge_enable_out)
		else $error("Bridge on with stalled oscillator");
	AST_SDO_HOLD: assert property (serial_clk_in [*6] ##0 (serial_out_oe_out
		&& $past(serial_out_oe_out)) |-> $stable(serial_out_out))
		else $error("Serial output changed without clock fall");
endmodule
bind stepper_ctrl stepper_ctrl_check chk_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
	.step_in(step_in), .fault_clear_sleep_n_in(fault_clear_sleep_n_in), .enable_in(enable_in),
	.serial_clk_in(serial_clk_in), .serial_strobe_n_in(serial_strobe_n_in),
	.oscillator_pin_in(oscillator_pin_in), .serial_out_out(serial_out_out),
	.serial_out_oe_out(serial_out_oe_out), .bridge_enable_out(bridge_enable_out),
	.sleep_out(sleep_out), .ext_clock_sel_out(ext_clock_sel_out),
	.phase_angle_out(phase_angle_out));

//--- common/pin_sync_if.sv
// Synchronised pin levels and edge pulses passed between design modules
`timescale 1ns/1ps
interface pin_sync_if #(parameter int N = stepper_pkg::NPIN);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

//--- common/stepper_pkg.sv
// Constants, field positions and types shared by the stepper control front end
package stepper_pkg;
	// Core clock rate
	localparam int CLK_MHZ = 40;
	// Reset pin held low this long forces sleep (least time, rounds up)
	localparam int SLEEP_WIDTH_NS = 10000;
	localparam int SLEEP_CYC = (SLEEP_WIDTH_NS * CLK_MHZ + 999) / 1000;
	// Oscillator pin watchdog time (typical figure, rounds down)
	localparam int CLOCK_LOSS_TIMEOUT_NS = 1000;
	localparam int WD_CYC = (CLOCK_LOSS_TIMEOUT_NS * CLK_MHZ) / 1000;
	// Synchronised pin indices
	localparam int NPIN = 10;
	localparam int P_STEP = 0;
	localparam int P_DIR = 1;
	localparam int P_CLRN = 2;
	localparam int P_EN = 3;
	localparam int P_SCLK = 4;
	localparam int P_SDI = 5;
	localparam int P_SERIAL_STROBE_N = 6;
	localparam int P_OSC = 7;
	localparam int P_MSLO = 8;
	localparam int P_MSHI = 9;
	// Idle level of each pin after reset (strobe, serial clock and reset pin idle high)
	localparam logic [NPIN-1:0] PIN_INIT = 10'h054;
	// Serial frame
	localparam int WORD_W = 16;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] BITCNT_RST = 5'h00;
	// Serial word selector in the top two bits
	localparam logic [1:0] SEL_CFG0 = 2'h0;
	localparam logic [1:0] SEL_CFG1 = 2'h1;
	localparam logic [1:0] SEL_STEP = 2'h2;
	localparam logic [1:0] SEL_DIAGNOSTIC_PIN = 2'h3;
	// APB register byte offsets
	localparam logic [7:0] OFS_CFG0 = 8'h00;
	localparam logic [7:0] OFS_CFG1 = 8'h04;
	localparam logic [7:0] OFS_STEP = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	// Configuration fields
	localparam int CFG0_MS_LSB = 0;
	localparam int CFG0_SERIAL_BIT = 2;
	localparam int CFG1_DIAGNOSTIC_PIN_LSB = 0;
	localparam int CFG1_EXTCLK_BIT = 13;
	localparam logic [15:0] CFG0_RST = 16'h0000;
	localparam logic [15:0] CFG1_RST = 16'h0000;
	localparam logic [5:0] DELTA_RST = 6'h00;
	// Phase angle number after reset (home position)
	localparam logic [5:0] ANGLE_HOME = 6'h08;
	// Step increments per microstep mode
	localparam logic [5:0] INC_FULL = 6'h10;
	localparam logic [5:0] INC_HALF = 6'h08;
	localparam logic [5:0] INC_QUARTER = 6'h04;
	localparam logic [5:0] INC_SIXTEENTH = 6'h01;
	// Diagnostic pin selections
	localparam logic [1:0] DIAGNOSTIC_PIN_FAULT = 2'h0;
	localparam logic [1:0] DIAGNOSTIC_PIN_CLKLOST = 2'h1;
	localparam logic [1:0] DIAGNOSTIC_PIN_HOME = 2'h2;
	localparam logic [1:0] DIAGNOSTIC_PIN_SLEEP = 2'h3;
	// Status word bit positions
	localparam int ST_ANGLE_LSB = 0;
	localparam int ST_CLKLOSS_FLT = 8;
	localparam int ST_FRAME_FLT = 9;
	localparam int ST_SUMMARY = 15;
	localparam int ST_SLEEP = 16;
	localparam int ST_BRIDGE = 17;
	localparam int ST_CLKLOST_NOW = 18;
	// Reset pin state machine
	typedef enum logic [1:0] {RST_IDLE, RST_LOW, RST_SLEEP} rst_state_t;
endpackage

//--- rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_sync (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [stepper_pkg::NPIN-1:0] pins_in,
	pin_sync_if.src sync_out
);
	logic [stepper_pkg::NPIN-1:0] s1;
	logic [stepper_pkg::NPIN-1:0] s2;
	logic [stepper_pkg::NPIN-1:0] s3;
	logic [stepper_pkg::NPIN-1:0] level;
	logic [stepper_pkg::NPIN-1:0] rise;
	logic [stepper_pkg::NPIN-1:0] fall;

	genvar i;
	generate
		for (i = 0; i < stepper_pkg::NPIN; i++) begin : g_pin
			// Shift chain; the level moves only when stages two and three agree
			always_ff @(posedge mclk_in) begin
				if (!rstn_in) begin
					s1[i] <= stepper_pkg::PIN_INIT[i];
					s2[i] <= stepper_pkg::PIN_INIT[i];
					s3[i] <= stepper_pkg::PIN_INIT[i];
					level[i] <= stepper_pkg::PIN_INIT[i];
					rise[i] <= 1'b0;
					fall[i] <= 1'b0;
				end else begin
					s1[i] <= pins_in[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) begin
						level[i] <= s3[i];
					end
					rise[i] <= (s2[i] == s3[i]) && s3[i] && !level[i];
					fall[i] <= (s2[i] == s3[i]) && !s3[i] && level[i];
				end
			end
		end
	endgenerate

	// Level changes together with its edge pulse
	assign sync_out.level = level;
	assign sync_out.rise = rise;
	assign sync_out.fall = fall;
endmodule

//--- rtl/stepper_ctrl.sv
// Stepper driver control front end: step sequencer, serial port, reset and clock watchdog
//
// Operation
// - Each step rising edge advances one sequence step
// - Direction is sampled only at step rise
// - Direction high increments, low decrements angle
// - Serial step mode ignores the direction input
// - Short reset pulse clears latched faults only
// - Reset held beyond shutdown width enters sleep
// - Shutdown width is ten microseconds minimum
// - Enable low turns every bridge output off
// - Sequencer keeps tracking while outputs disabled
// - Serial word is sixteen bits, MSB first
// - Serial output floats while strobe is high
// - Strobe fall drives summary fault flag out
// - Serial input sampled on serial clock rise
// - Serial output updates after serial clock fall
// - Strobe high ignores serial clock and data
// - Diagnostic pin selectable, defaults to fault
// - Bit 13 clear selects internal oscillator
// - Bit 13 set selects external clock pin
// - Stalled external clock sets fault, disables outputs
`timescale 1ns/1ps
module stepper_ctrl (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic step_in,
	input wire logic direction_in,
	input wire logic fault_clear_sleep_n_in,
	input wire logic enable_in,
	input wire logic serial_clk_in,
	input wire logic serial_in_in,
	input wire logic serial_strobe_n_in,
	input wire logic oscillator_pin_in,
	input wire logic microstep_select_lo_in,
	input wire logic microstep_select_hi_in,
	output logic serial_out_out,
	output logic serial_out_oe_out,
	output logic diagnostic_pin_out,
	output logic bridge_enable_out,
	output logic sleep_out,
	output logic ext_clock_sel_out,
	output logic [5:0] phase_angle_out
);
	pin_sync_if sync ();

	logic [stepper_pkg::NPIN-1:0] pins;
	logic [15:0] cfg0;
	logic [15:0] cfg1;
	logic [5:0] delta;
	logic [5:0] angle;
	logic [5:0] inc;
	logic [1:0] ms;
	stepper_pkg::rst_state_t rst_state;
	logic [15:0] low_cnt;
	logic clear_faults;
	logic sleeping;
	logic [7:0] wd_cnt;
	logic clock_lost;
	logic clkloss_flt;
	logic frame_flt;
	logic summary;
	logic [31:0] status;
	logic strobe_active;
	logic [15:0] shift_in;
	logic [15:0] shift_out;
	logic [4:0] bit_cnt;
	logic frame_done;
	logic frame_bad;
	logic apb_setup;
	logic apb_write;
	logic mapped;

	// Gather all pins from outside the clock domain
	always_comb begin
		pins = '0;
		pins[stepper_pkg::P_STEP] = step_in;
		pins[stepper_pkg::P_DIR] = direction_in;
		pins[stepper_pkg::P_CLRN] = fault_clear_sleep_n_in;
		pins[stepper_pkg::P_EN] = enable_in;
		pins[stepper_pkg::P_SCLK] = serial_clk_in;
		pins[stepper_pkg::P_SDI] = serial_in_in;
		pins[stepper_pkg::P_SERIAL_STROBE_N] = serial_strobe_n_in;
		pins[stepper_pkg::P_OSC] = oscillator_pin_in;
		pins[stepper_pkg::P_MSLO] = microstep_select_lo_in;
		pins[stepper_pkg::P_MSHI] = microstep_select_hi_in;
	end

	pin_sync u_sync (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.pins_in(pins),
		.sync_out(sync)
	);

	// Step size from pins ORed with the configuration bits
	always_comb begin
		ms = cfg0[stepper_pkg::CFG0_MS_LSB +: 2]
			| {sync.level[stepper_pkg::P_MSHI], sync.level[stepper_pkg::P_MSLO]};
		case (ms)
			2'h0: inc = stepper_pkg::INC_FULL;
			2'h1: inc = stepper_pkg::INC_HALF;
			2'h2: inc = stepper_pkg::INC_QUARTER;
			2'h3: inc = stepper_pkg::INC_SIXTEENTH;
			default: inc = stepper_pkg::INC_FULL;
		endcase
	end

	// Phase angle sequencer, runs whatever the enable and sleep state
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			angle <= stepper_pkg::ANGLE_HOME;
		end else if (sync.rise[stepper_pkg::P_STEP]) begin
			if (cfg0[stepper_pkg::CFG0_SERIAL_BIT]) begin
				angle <= angle + delta;
			end else if (sync.level[stepper_pkg::P_DIR]) begin
				angle <= angle + inc;
			end else begin
				angle <= angle - inc;
			end
		end
	end

	// Reset pin: short low clears faults, long low puts the core to sleep
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			rst_state <= stepper_pkg::RST_IDLE;
			low_cnt <= 16'h0000;
		end else begin
			case (rst_state)
				stepper_pkg::RST_IDLE: begin
					low_cnt <= 16'h0000;
					if (!sync.level[stepper_pkg::P_CLRN]) begin
						rst_state <= stepper_pkg::RST_LOW;
					end
				end
				stepper_pkg::RST_LOW: begin
					low_cnt <= low_cnt + 16'h0001;
					if (sync.level[stepper_pkg::P_CLRN]) begin
						rst_state <= stepper_pkg::RST_IDLE;
					end else if (low_cnt == 16'(stepper_pkg::SLEEP_CYC - 1)) begin
						rst_state <= stepper_pkg::RST_SLEEP;
					end
				end
				stepper_pkg::RST_SLEEP: begin
					if (sync.level[stepper_pkg::P_CLRN]) begin
						rst_state <= stepper_pkg::RST_IDLE;
					end
				end
				default: rst_state <= stepper_pkg::RST_IDLE;
			endcase
		end
	end

	// Faults clear when the reset pin returns high, from a pulse or from sleep
	assign clear_faults = (rst_state != stepper_pkg::RST_IDLE)
		&& sync.level[stepper_pkg::P_CLRN];
	assign sleeping = (rst_state == stepper_pkg::RST_SLEEP);

	// Oscillator pin watchdog counts cycles since its last edge; held at zero
	// outside external mode so that entering it raises no stale fault
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			wd_cnt <= 8'h00;
		end else if (!cfg1[stepper_pkg::CFG1_EXTCLK_BIT]
			|| sync.rise[stepper_pkg::P_OSC] || sync.fall[stepper_pkg::P_OSC]) begin
			wd_cnt <= 8'h00;
		end else if (wd_cnt != 8'hFF) begin
			wd_cnt <= wd_cnt + 8'h01;
		end
	end

	// Clock loss only counts in external clock mode
	assign clock_lost = cfg1[stepper_pkg::CFG1_EXTCLK_BIT]
		&& (wd_cnt > 8'(stepper_pkg::WD_CYC));

	// Latched faults; a new event wins over a clear in the same cycle
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			clkloss_flt <= 1'b0;
		end else if (clock_lost) begin
			clkloss_flt <= 1'b1;
		end else if (clear_faults) begin
			clkloss_flt <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			frame_flt <= 1'b0;
		end else if (frame_bad) begin
			frame_flt <= 1'b1;
		end else if (clear_faults) begin
			frame_flt <= 1'b0;
		end
	end

	// Status word, low half is the diagnostic word sent on the serial port
	always_comb begin
		summary = clkloss_flt | frame_flt;
		status = 32'h00000000;
		status[stepper_pkg::ST_ANGLE_LSB +: 6] = angle;
		status[stepper_pkg::ST_CLKLOSS_FLT] = clkloss_flt;
		status[stepper_pkg::ST_FRAME_FLT] = frame_flt;
		status[stepper_pkg::ST_SUMMARY] = summary;
		status[stepper_pkg::ST_SLEEP] = sleeping;
		status[stepper_pkg::ST_BRIDGE] = bridge_enable_out;
		status[stepper_pkg::ST_CLKLOST_NOW] = clock_lost;
	end

	// Serial frame qualifiers; nothing moves while the strobe is high
	assign strobe_active = !sync.level[stepper_pkg::P_SERIAL_STROBE_N];
	assign frame_done = sync.rise[stepper_pkg::P_SERIAL_STROBE_N] && (bit_cnt == stepper_pkg::FRAME_BITS);
	assign frame_bad = sync.rise[stepper_pkg::P_SERIAL_STROBE_N] && (bit_cnt != stepper_pkg::FRAME_BITS);

	// Receive shift register and edge counter
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			shift_in <= 16'h0000;
			bit_cnt <= stepper_pkg::BITCNT_RST;
		end else if (sync.fall[stepper_pkg::P_SERIAL_STROBE_N]) begin
			shift_in <= 16'h0000;
			bit_cnt <= stepper_pkg::BITCNT_RST;
		end else if (strobe_active && sync.rise[stepper_pkg::P_SCLK]) begin
			shift_in <= {shift_in[14:0], sync.level[stepper_pkg::P_SDI]};
			if (bit_cnt != 5'h1F) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// Transmit side: summary flag first, next bit after each clock fall
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			shift_out <= 16'h0000;
			serial_out_out <= 1'b0;
			serial_out_oe_out <= 1'b0;
		end else if (sync.fall[stepper_pkg::P_SERIAL_STROBE_N]) begin
			shift_out <= status[15:0];
			serial_out_out <= status[stepper_pkg::ST_SUMMARY];
			serial_out_oe_out <= 1'b1;
		end else if (!strobe_active) begin
			serial_out_oe_out <= 1'b0;
		end else if (sync.fall[stepper_pkg::P_SCLK]) begin
			shift_out <= {shift_out[14:0], 1'b0};
			serial_out_out <= shift_out[14];
		end
	end

	// APB decode
	assign apb_setup = psel_in && !penable_in;
	assign apb_write = psel_in && penable_in && pwrite_in;
	assign mapped = (paddr_in == stepper_pkg::OFS_CFG0) || (paddr_in == stepper_pkg::OFS_CFG1)
		|| (paddr_in == stepper_pkg::OFS_STEP) || (paddr_in == stepper_pkg::OFS_STATUS);
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !mapped;

	// Read data captured in the setup cycle
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			prdata_out <= 32'h00000000;
		end else if (apb_setup) begin
			case (paddr_in)
				stepper_pkg::OFS_CFG0: prdata_out <= {16'h0000, cfg0};
				stepper_pkg::OFS_CFG1: prdata_out <= {16'h0000, cfg1};
				stepper_pkg::OFS_STEP: prdata_out <= {26'h0000000, delta};
				stepper_pkg::OFS_STATUS: prdata_out <= status;
				default: prdata_out <= 32'h00000000;
			endcase
		end
	end

	// Configuration from serial frames, with a bus write taking priority
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			cfg0 <= stepper_pkg::CFG0_RST;
			cfg1 <= stepper_pkg::CFG1_RST;
			delta <= stepper_pkg::DELTA_RST;
		end else begin
			if (frame_done) begin
				case (shift_in[15:14])
					stepper_pkg::SEL_CFG0: cfg0 <= shift_in;
					stepper_pkg::SEL_CFG1: cfg1 <= shift_in;
					stepper_pkg::SEL_STEP: delta <= shift_in[5:0];
					stepper_pkg::SEL_DIAGNOSTIC_PIN: cfg0 <= cfg0;
					default: cfg0 <= cfg0;
				endcase
			end
			if (apb_write && paddr_in == stepper_pkg::OFS_CFG0) begin
				cfg0 <= pwdata_in[15:0];
			end
			if (apb_write && paddr_in == stepper_pkg::OFS_CFG1) begin
				cfg1 <= pwdata_in[15:0];
			end
			if (apb_write && paddr_in == stepper_pkg::OFS_STEP) begin
				delta <= pwdata_in[5:0];
			end
		end
	end

	// Output pins and diagnostic selector
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			bridge_enable_out <= 1'b0;
			diagnostic_pin_out <= 1'b0;
		end else begin
			bridge_enable_out <= sync.level[stepper_pkg::P_EN]
				&& !sleeping && !clock_lost;
			case (cfg1[stepper_pkg::CFG1_DIAGNOSTIC_PIN_LSB +: 2])
				stepper_pkg::DIAGNOSTIC_PIN_FAULT: diagnostic_pin_out <= summary;
				stepper_pkg::DIAGNOSTIC_PIN_CLKLOST: diagnostic_pin_out <= clock_lost;
				stepper_pkg::DIAGNOSTIC_PIN_HOME: diagnostic_pin_out <= (angle == stepper_pkg::ANGLE_HOME);
				stepper_pkg::DIAGNOSTIC_PIN_SLEEP: diagnostic_pin_out <= sleeping;
				default: diagnostic_pin_out <= summary;
			endcase
		end
	end

	// Oscillator source select is a plain pin toward the clock generator
	assign ext_clock_sel_out = cfg1[stepper_pkg::CFG1_EXTCLK_BIT];
	assign sleep_out = sleeping;
	assign phase_angle_out = angle;
endmodule
